// ---- rtl/cfh_port.sv ----
// Notes on behaviour
// R1: command request stays high except while a command cannot be taken.
// R2: host drives command word, then raises command acknowledge.
// R3: on command acknowledge the command request drops.
// R4: on acknowledge the word is sampled and devices enabled or disabled.
// R5: host then drops acknowledge and clears its data lines.
// R6: command word is seven bits, each position selects a function.
// R7: printer/punch enabled when bit 0 and its select bit are set.
// R8: output device disabled when bit 0 set and its select clear.
// R9: keyboard/reader enabled when bit 3 and select bit(s) are set.
// R10: input device disabled when bit 3 set and its select clear.
// R11: with an output device enabled, output request asks for a word.
// R12: host drives data and output acknowledge, loading output register.
// R13: output register goes to printer, punch, or both as enabled.
// R14: after each print/punch cycle, clear register and request again.
// R15: word transfers repeat until the host ends the operation.
// R16: keyboard or reader loading input register raises input request.
// R17: host samples, acknowledges; input register clears on acknowledge.
// R18: each command acknowledge yields a 2 us internal enable pulse.
// R19: during that pulse print and punch flags load from the word.
// R20: the enable pulse clears the off-line flag.
// R21: request held low for 70 ms after acknowledge, then released.
// R22: host handshakes are synchronised; acknowledges are edge detected.
//
// Chosen here: the APB slave port and the register addresses.
module cfh_port #(
    parameter int DW = 8,
    parameter int AW = 12,
    parameter int unsigned STRETCH_CYC = cfh_pkg::STRETCH_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // host channel
    input wire logic [DW-1:0] host_data_i,
    output logic command_request_o,
    input wire logic command_acknowledge_i,
    output logic out_req_o,
    input wire logic out_ack_i,
    output logic in_req_o,
    input wire logic in_ack_i,
    output logic [DW-1:0] in_data_o,
    // printer and punch
    output logic [DW-1:0] out_data_o,
    output logic prn_go_o,
    input wire logic prn_done_i,
    output logic pun_go_o,
    input wire logic pun_done_i,
    // keyboard and reader
    input wire logic [DW-1:0] kbd_char_i,
    input wire logic kbd_load_i,
    input wire logic [DW-1:0] rdr_char_i,
    input wire logic rdr_load_i,
    // mode flags
    output logic offline_o,
    output logic prn_en_o,
    output logic pun_en_o,
    output logic kbd_en_o,
    output logic rdr_en_o
);
    localparam int CW = $clog2(STRETCH_CYC + 1);
    localparam logic [CW-1:0] PULSE_END = CW'(cfh_pkg::PULSE_CYC);
    localparam logic [CW-1:0] STR_END = CW'(STRETCH_CYC);

    typedef struct packed {
        cfh_pkg::cfh_cmd_st_t st;
        logic [CW-1:0] cnt;
        logic [cfh_pkg::CMD_W-1:0] cmd;
        logic offline;
        logic prn_en;
        logic pun_en;
        logic kbd_en;
        logic rdr_en;
        logic [DW-1:0] out_reg;
        logic out_full;
        logic prn_busy;
        logic pun_busy;
        logic [DW-1:0] in_reg;
        logic in_full;
        logic [cfh_pkg::SYN_W-1:0] syn_q;
        logic [31:0] prdata;
    } cfh_port_st_t;

    cfh_port_st_t st_ff;
    cfh_port_st_t nxt_st;
    logic [cfh_pkg::SYN_W-1:0] syn_raw;
    logic [cfh_pkg::SYN_W-1:0] syn;
    logic [cfh_pkg::SYN_W-1:0] rise;
    logic cmd_req;
    logic out_req;
    logic setup_rd;
    logic wr_go;

    // true when an address is one of the four mapped words
    function automatic logic addr_hit(input logic [AW-1:0] a);
        logic [11:0] w;
        w = 12'(a);
        return (w == cfh_pkg::ADDR_STAT) || (w == cfh_pkg::ADDR_CTRL) ||
               (w == cfh_pkg::ADDR_OUTR) || (w == cfh_pkg::ADDR_INR);
    endfunction

    // read value for an address; unmapped reads give zero
    function automatic logic [31:0] rd_val(input logic [AW-1:0] a,
                                           input cfh_port_st_t s,
                                           input logic req);
        logic [31:0] v;
        v = '0;
        case (12'(a))
            cfh_pkg::ADDR_STAT: begin
                v[cfh_pkg::ST_OFFLINE] = s.offline;
                v[cfh_pkg::ST_PRN_EN] = s.prn_en;
                v[cfh_pkg::ST_PUN_EN] = s.pun_en;
                v[cfh_pkg::ST_KBD_EN] = s.kbd_en;
                v[cfh_pkg::ST_RDR_EN] = s.rdr_en;
                v[cfh_pkg::ST_CMD_REQ] = req;
                v[cfh_pkg::ST_OUT_FULL] = s.out_full;
                v[cfh_pkg::ST_IN_FULL] = s.in_full;
                v[cfh_pkg::ST_PRN_BUSY] = s.prn_busy;
                v[cfh_pkg::ST_PUN_BUSY] = s.pun_busy;
            end
            cfh_pkg::ADDR_CTRL: v = '0;
            cfh_pkg::ADDR_OUTR: v[DW-1:0] = s.out_reg;
            cfh_pkg::ADDR_INR: v[DW-1:0] = s.in_reg;
            default: v = '0;
        endcase
        return v;
    endfunction

    // host handshakes and mechanism strobes all come from other domains
    assign syn_raw[cfh_pkg::SYN_CMD_ACK] = command_acknowledge_i; // R22
    assign syn_raw[cfh_pkg::SYN_OUT_ACK] = out_ack_i;
    assign syn_raw[cfh_pkg::SYN_IN_ACK] = in_ack_i;
    assign syn_raw[cfh_pkg::SYN_PRN_DONE] = prn_done_i;
    assign syn_raw[cfh_pkg::SYN_PUN_DONE] = pun_done_i;
    assign syn_raw[cfh_pkg::SYN_KBD_LOAD] = kbd_load_i;
    assign syn_raw[cfh_pkg::SYN_RDR_LOAD] = rdr_load_i;

    cfh_sync #(
        .W(cfh_pkg::SYN_W)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .async_i(syn_raw),
        .sync_o(syn)
    );

    // rising edges of the filtered inputs
    assign rise = syn & ~st_ff.syn_q; // R22

    // handshake outputs
    assign cmd_req = (st_ff.st == cfh_pkg::CFH_IDLE); // R1 R21
    assign out_req = !st_ff.offline && (st_ff.prn_en || st_ff.pun_en) &&
                     !st_ff.out_full; // R11 R14
    assign setup_rd = psel_i && !penable_i && !pwrite_i;
    assign wr_go = psel_i && penable_i && pwrite_i &&
                   (12'(paddr_i) == cfh_pkg::ADDR_CTRL);

    // next state of the whole port
    always_comb begin
        nxt_st = st_ff;
        nxt_st.syn_q = syn;
        // command sequencer: pulse, then stretch, then accept again
        case (st_ff.st)
            cfh_pkg::CFH_IDLE: begin
                if (rise[cfh_pkg::SYN_CMD_ACK]) begin
                    // word lines settled before the ack, so no extra sync
                    nxt_st.cmd = host_data_i[cfh_pkg::CMD_W-1:0]; // R4 R6
                    nxt_st.st = cfh_pkg::CFH_PULSE; // R3
                    nxt_st.cnt = CW'(1);
                end
            end
            cfh_pkg::CFH_PULSE: begin
                nxt_st.cnt = st_ff.cnt + CW'(1);
                nxt_st.offline = 1'b0; // R20
                if (st_ff.cmd[cfh_pkg::CMD_OUT_EN]) begin // R19
                    nxt_st.prn_en = st_ff.cmd[cfh_pkg::CMD_PRN_SEL]; // R7 R8
                    nxt_st.pun_en = st_ff.cmd[cfh_pkg::CMD_PUN_SEL]; // R7 R8
                end
                if (st_ff.cmd[cfh_pkg::CMD_IN_EN]) begin
                    nxt_st.kbd_en = st_ff.cmd[cfh_pkg::CMD_KBD_SEL]; // R9 R10
                    nxt_st.rdr_en = st_ff.cmd[cfh_pkg::CMD_RDR_SEL_A] &&
                                    st_ff.cmd[cfh_pkg::CMD_RDR_SEL_B]; // R9
                end
                if (st_ff.cnt >= PULSE_END) begin // R18
                    nxt_st.st = cfh_pkg::CFH_STRETCH;
                end
            end
            cfh_pkg::CFH_STRETCH: begin
                nxt_st.cnt = st_ff.cnt + CW'(1);
                if (st_ff.cnt >= STR_END) begin // R21
                    nxt_st.st = cfh_pkg::CFH_IDLE;
                    nxt_st.cnt = '0;
                end
            end
            default: begin
                nxt_st.st = cfh_pkg::CFH_IDLE;
                nxt_st.cnt = '0;
            end
        endcase
        // software can force off-line; the next command pulse undoes it
        if (wr_go && pwdata_i[cfh_pkg::CT_GO_OFFLINE]) begin
            nxt_st.offline = 1'b1;
        end
        // output path: a done edge ends that mechanism's cycle
        if (rise[cfh_pkg::SYN_PRN_DONE]) begin
            nxt_st.prn_busy = 1'b0;
        end
        if (rise[cfh_pkg::SYN_PUN_DONE]) begin
            nxt_st.pun_busy = 1'b0;
        end
        if (st_ff.out_full && !nxt_st.prn_busy && !nxt_st.pun_busy) begin
            nxt_st.out_full = 1'b0; // R14
            nxt_st.out_reg = '0;
        end
        if (out_req && rise[cfh_pkg::SYN_OUT_ACK]) begin // R12 R15
            nxt_st.out_reg = host_data_i;
            nxt_st.out_full = 1'b1;
            nxt_st.prn_busy = st_ff.prn_en; // R13
            nxt_st.pun_busy = st_ff.pun_en; // R13
        end
        // input path: a new load beats an ack in the same cycle
        if (rise[cfh_pkg::SYN_IN_ACK] && st_ff.in_full) begin
            nxt_st.in_full = 1'b0; // R17
            nxt_st.in_reg = '0;
        end
        if (!st_ff.offline && !nxt_st.in_full) begin
            if (st_ff.kbd_en && rise[cfh_pkg::SYN_KBD_LOAD]) begin
                nxt_st.in_reg = kbd_char_i; // R16 R15
                nxt_st.in_full = 1'b1;
            end else if (st_ff.rdr_en && rise[cfh_pkg::SYN_RDR_LOAD]) begin
                nxt_st.in_reg = rdr_char_i; // R16 R15
                nxt_st.in_full = 1'b1;
            end
        end
        // read data is prepared in the setup phase, ready in the access
        if (setup_rd) begin
            nxt_st.prdata = rd_val(paddr_i, st_ff, cmd_req);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
            st_ff.st <= cfh_pkg::CFH_IDLE;
            st_ff.offline <= cfh_pkg::RST_OFFLINE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // apb answers in the first access cycle
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_hit(paddr_i);
    assign prdata_o = st_ff.prdata;

    // host and mechanism outputs
    assign command_request_o = cmd_req;
    assign out_req_o = out_req;
    assign in_req_o = st_ff.in_full; // R16
    assign in_data_o = st_ff.in_reg;
    assign out_data_o = st_ff.out_reg; // R13
    assign prn_go_o = st_ff.prn_busy;
    assign pun_go_o = st_ff.pun_busy;
    assign offline_o = st_ff.offline;
    assign prn_en_o = st_ff.prn_en;
    assign pun_en_o = st_ff.pun_en;
    assign kbd_en_o = st_ff.kbd_en;
    assign rdr_en_o = st_ff.rdr_en;
endmodule // cfh_port

// ---- inc/cfh_pkg.sv ----
package cfh_pkg;
    // timing figures as printed, and the cycle counts derived from them
    localparam int unsigned REF_CLK_HZ = 20_000_000;
    localparam int unsigned PULSE_NS = 2000;
    localparam int unsigned STRETCH_MS = 70;
    localparam int unsigned PULSE_CYC =
        (PULSE_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned STRETCH_CYC = STRETCH_MS * (REF_CLK_HZ / 1000);

    // command word layout (seven bits, position encoded)
    localparam int CMD_W = 7;
    localparam int CMD_OUT_EN = 0;
    localparam int CMD_PRN_SEL = 1;
    localparam int CMD_PUN_SEL = 2;
    localparam int CMD_IN_EN = 3;
    localparam int CMD_KBD_SEL = 4;
    localparam int CMD_RDR_SEL_A = 5;
    localparam int CMD_RDR_SEL_B = 6;

    // synchronised input vector positions
    localparam int SYN_W = 7;
    localparam int SYN_CMD_ACK = 0;
    localparam int SYN_OUT_ACK = 1;
    localparam int SYN_IN_ACK = 2;
    localparam int SYN_PRN_DONE = 3;
    localparam int SYN_PUN_DONE = 4;
    localparam int SYN_KBD_LOAD = 5;
    localparam int SYN_RDR_LOAD = 6;

    // register map (byte addresses)
    localparam logic [11:0] ADDR_STAT = 12'h000;
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    localparam logic [11:0] ADDR_OUTR = 12'h008;
    localparam logic [11:0] ADDR_INR = 12'h00c;

    // status register fields
    localparam int ST_OFFLINE = 0;
    localparam int ST_PRN_EN = 1;
    localparam int ST_PUN_EN = 2;
    localparam int ST_KBD_EN = 3;
    localparam int ST_RDR_EN = 4;
    localparam int ST_CMD_REQ = 5;
    localparam int ST_OUT_FULL = 6;
    localparam int ST_IN_FULL = 7;
    localparam int ST_PRN_BUSY = 8;
    localparam int ST_PUN_BUSY = 9;
    // control register fields
    localparam int CT_GO_OFFLINE = 0;

    localparam logic RST_OFFLINE = 1'h1;

    // command handshake sequencer; one bit changes per step except stretch back to idle
    typedef enum logic [1:0] {
        CFH_IDLE = 2'h0,
        CFH_PULSE = 2'h1,
        CFH_STRETCH = 2'h3
    } cfh_cmd_st_t;
endpackage

// ---- rtl/cfh_sync.sv ----
// three-stage synchroniser; output moves only when stages two and three agree
module cfh_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // asynchronous in, synchronous out
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } cfh_sync_st_t;

    cfh_sync_st_t st_ff;
    cfh_sync_st_t nxt_st;

    // s1 feeds only s2, so metastability never reaches the filter
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = async_i;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.q = (~(st_ff.s2 ^ st_ff.s3) & st_ff.s3) |
                   ((st_ff.s2 ^ st_ff.s3) & st_ff.q);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_o = st_ff.q;
endmodule // cfh_sync

// ---- test/cfh_port_checker.sv ----
// watches the host channel of the port
module cfh_port_checker #(
    parameter int unsigned STRETCH_CYC = 100
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // host channel
    input wire logic command_request_o,
    input wire logic command_acknowledge_i,
    input wire logic out_req_o,
    input wire logic in_req_o,
    input wire logic in_ack_i,
    input wire logic [7:0] host_data_i,
    input wire logic [7:0] in_data_o,
    input wire logic [7:0] out_data_o,
    // mechanisms and mode flags
    input wire logic prn_go_o,
    input wire logic pun_go_o,
    input wire logic offline_o,
    input wire logic prn_en_o,
    input wire logic pun_en_o,
    input wire logic kbd_en_o,
    input wire logic rdr_en_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned LIM = cfh_pkg::PULSE_CYC + STRETCH_CYC + 4;
    int unsigned lo_cnt;
    logic req_q;
    logic [6:0] cw_q;
    // low time of the request, and the word seen as it fell
    always_ff @(posedge ref_clk_i) begin
        req_q <= command_request_o;
        lo_cnt <= (!resetn_i || command_request_o) ? 0 : lo_cnt + 1;
        if (req_q && !command_request_o) cw_q <= host_data_i[6:0];
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_cmd_taken;
        command_request_o ##1 !command_request_o;
    endsequence
    // a drop caused by offline or a disable is not a word taken
    sequence s_out_taken;
        out_req_o ##1 !out_req_o && !offline_o && (prn_en_o || pun_en_o);
    endsequence
    AST_CMD_DROP: assert property ($rose(command_acknowledge_i) &&
        command_request_o |-> ##[3:6] !command_request_o)
        else $error("command request held after acknowledge");
    AST_CMD_HELD: assert property ($rose(command_request_o) |->
        lo_cnt >= STRETCH_CYC - 1 && lo_cnt <= LIM)
        else $error("command request low time out of range");
    AST_OFFLINE: assert property (s_cmd_taken |-> ##[1:3] !offline_o)
        else $error("offline flag not cleared by command");
    AST_OUT_EN: assert property (s_cmd_taken |-> ##3 (!cw_q[0] ||
        prn_en_o == cw_q[1] && pun_en_o == cw_q[2]))
        else $error("output enables differ from command word");
    AST_IN_EN: assert property (s_cmd_taken |-> ##3 (!cw_q[3] ||
        kbd_en_o == cw_q[4] && rdr_en_o == (cw_q[5] && cw_q[6])))
        else $error("input enables differ from command word");
    AST_OUT_REQ: assert property (out_req_o |-> !offline_o &&
        (prn_en_o || pun_en_o) && out_data_o == 8'h00)
        else $error("output request without enabled empty register");
    AST_OUT_GO: assert property (s_out_taken |->
        prn_go_o == prn_en_o && pun_go_o == pun_en_o)
        else $error("output word not sent to enabled mechanisms");
    AST_IN_CLR: assert property ($rose(in_ack_i) && in_req_o |->
        ##[3:6] !in_req_o && in_data_o == 8'h00)
        else $error("input register not cleared by acknowledge");
endmodule // cfh_port_checker

bind cfh_port cfh_port_checker #(.STRETCH_CYC(STRETCH_CYC)) u_chk (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .command_request_o(command_request_o),
    .command_acknowledge_i(command_acknowledge_i),
    .out_req_o(out_req_o),
    .in_req_o(in_req_o),
    .in_ack_i(in_ack_i),
    .host_data_i(host_data_i),
    .in_data_o(in_data_o),
    .out_data_o(out_data_o),
    .prn_go_o(prn_go_o),
    .pun_go_o(pun_go_o),
    .offline_o(offline_o),
    .prn_en_o(prn_en_o),
    .pun_en_o(pun_en_o),
    .kbd_en_o(kbd_en_o),
    .rdr_en_o(rdr_en_o)
);

// ---- test/cfh_host.sv ----
// host computer model: answers at once or after slow extra cycles
module cfh_host (
    // clock and requests from the port
    input wire logic ref_clk_i,
    input wire logic command_request_i,
    input wire logic out_req_i,
    input wire logic in_req_i,
    // lines the host drives
    output logic [7:0] host_data_o,
    output logic command_acknowledge_o,
    output logic out_ack_o,
    output logic in_ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int slow = 0;
    logic [7:0] txq[$];
    // word settles a cycle before the acknowledge; both held until taken
    task automatic send_cmd(input logic [6:0] w);
        @(negedge ref_clk_i iff command_request_i === 1'b1);
        repeat (slow + 1) @(posedge ref_clk_i);
        host_data_o <= {1'b0, w};
        @(posedge ref_clk_i);
        command_acknowledge_o <= 1'b1;
        @(negedge ref_clk_i iff command_request_i === 1'b0);
        @(posedge ref_clk_i);
        command_acknowledge_o <= 1'b0;
        host_data_o <= 8'h00;
    endtask
    // one queued word per output request
    initial begin
        host_data_o = 8'h00;
        command_acknowledge_o = 1'b0;
        out_ack_o = 1'b0;
        forever begin
            @(negedge ref_clk_i iff (out_req_i === 1'b1 && txq.size() > 0));
            repeat (slow + 1) @(posedge ref_clk_i);
            host_data_o <= txq.pop_front();
            @(posedge ref_clk_i);
            out_ack_o <= 1'b1;
            @(negedge ref_clk_i iff out_req_i === 1'b0);
            @(posedge ref_clk_i);
            out_ack_o <= 1'b0;
            host_data_o <= 8'h00;
        end
    end
    // every input request is taken and acknowledged
    initial begin
        in_ack_o = 1'b0;
        forever begin
            @(negedge ref_clk_i iff in_req_i === 1'b1);
            repeat (slow + 1) @(posedge ref_clk_i);
            in_ack_o <= 1'b1;
            @(negedge ref_clk_i iff in_req_i === 1'b0);
            @(posedge ref_clk_i);
            in_ack_o <= 1'b0;
        end
    end
endmodule // cfh_host

// ---- test/cfh_port_tb.sv ----
module cfh_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // apb, clock and reset
    logic ref_clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0;
    logic penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000, prdata_o;
    // host channel, mechanisms and flags
    logic command_request_o, command_acknowledge_i, out_req_o, out_ack_i;
    logic in_req_o, in_ack_i, prn_go_o, pun_go_o, offline_o;
    logic prn_en_o, pun_en_o, kbd_en_o, rdr_en_o;
    logic prn_done_i = 1'b0, pun_done_i = 1'b0;
    logic kbd_load_i = 1'b0, rdr_load_i = 1'b0;
    logic [7:0] kbd_char_i = 8'h00, rdr_char_i = 8'h00;
    logic [7:0] host_data_i, in_data_o, out_data_o;
    // bench state
    int err_count = 0, cmp_count = 0, cyc = 0;
    logic [16:0] rs = 17'h13213;
    logic [31:0] st = 32'h00000021;
    logic [7:0] oq[$], iq[$];
    logic ir_q = 1'b0, og_q = 1'b0;
    logic [6:0] oc[3] = '{7'h07, 7'h03, 7'h05};
    logic [6:0] cw[6] = '{7'h78, 7'h03, 7'h28, 7'h18, 7'h00, 7'h01};
    // short stretch keeps the run brief
    cfh_port #(
        .STRETCH_CYC(100)
    ) DUT (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .host_data_i(host_data_i), .command_request_o(command_request_o),
        .command_acknowledge_i(command_acknowledge_i),
        .out_req_o(out_req_o), .out_ack_i(out_ack_i),
        .in_req_o(in_req_o), .in_ack_i(in_ack_i), .in_data_o(in_data_o),
        .out_data_o(out_data_o), .prn_go_o(prn_go_o),
        .prn_done_i(prn_done_i), .pun_go_o(pun_go_o),
        .pun_done_i(pun_done_i), .kbd_char_i(kbd_char_i),
        .kbd_load_i(kbd_load_i), .rdr_char_i(rdr_char_i),
        .rdr_load_i(rdr_load_i), .offline_o(offline_o),
        .prn_en_o(prn_en_o), .pun_en_o(pun_en_o),
        .kbd_en_o(kbd_en_o), .rdr_en_o(rdr_en_o)
    );
    cfh_host host (.ref_clk_i(ref_clk_i),
        .command_request_i(command_request_o), .out_req_i(out_req_o),
        .in_req_i(in_req_o), .host_data_o(host_data_i),
        .command_acknowledge_o(command_acknowledge_i),
        .out_ack_o(out_ack_i), .in_ack_o(in_ack_i));
    // 20 mhz clock
    always #25 ref_clk_i = ~ref_clk_i;
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    // mechanisms finish after random stalls; the cycle limit ends a hang
    always @(posedge ref_clk_i) begin
        rs <= lfsr(rs);
        prn_done_i <= prn_go_o & rs[3];
        pun_done_i <= pun_go_o & rs[9];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    // register read data
    task automatic chk_rd(input string n, input logic [31:0] x, q);
        cmp_count++;
        if (q !== x) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, x, q);
        end
    endtask
    // bus error response
    task automatic chk_err(input string n, input logic x, q);
        cmp_count++;
        if (q !== x) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, x, q);
        end
    endtask
    // character words moved between host and mechanisms
    task automatic chk_io(input string n, input logic [7:0] x, q);
        cmp_count++;
        if (q !== x) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, x, q);
        end
    endtask
    // watcher: each new result against the oldest note
    always @(negedge ref_clk_i) begin
        if (in_req_o === 1'b1 && !ir_q) begin
            chk_io("in_data", iq.pop_front(), in_data_o);
        end
        if ((prn_go_o | pun_go_o) === 1'b1 && !og_q) begin
            chk_io("out_data", oq.pop_front(), out_data_o);
        end
        ir_q = in_req_o === 1'b1;
        og_q = (prn_go_o | pun_go_o) === 1'b1;
    end
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic er);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        @(posedge ref_clk_i iff pready_o === 1'b1);
        q = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
        input logic xe);
        logic [31:0] q;
        logic er;
        apb(1'b0, a, 32'h00000000, q, er);
        chk_rd("prdata", x, q);
        chk_err("pslverr", xe, er);
    endtask
    // expected status follows the command word bit by bit
    task automatic cmd(input logic [6:0] w);
        host.send_cmd(w);
        if (w[0]) st[2:1] = w[2:1];
        if (w[3]) st[4:3] = {w[5] & w[6], w[4]};
        st[0] = 1'b0;
        @(negedge ref_clk_i iff command_request_o === 1'b1);
        rd(12'h000, st, 1'b0);
    endtask
    // character held until the port raises its input request
    task automatic load(input logic k);
        logic [7:0] c;
        c = rs[7:0];
        iq.push_back(c);
        @(posedge ref_clk_i);
        kbd_char_i <= c;
        rdr_char_i <= c;
        kbd_load_i <= k;
        rdr_load_i <= !k;
        @(negedge ref_clk_i iff in_req_o === 1'b1);
        @(posedge ref_clk_i);
        kbd_load_i <= 1'b0;
        rdr_load_i <= 1'b0;
        @(negedge ref_clk_i iff in_req_o === 1'b0);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        logic [31:0] r;
        logic e;
        repeat (10) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rd(12'h000, st, 1'b0);
        rd(12'h010, 32'h00000000, 1'b1);
        foreach (cw[i]) cmd(cw[i]);
        cmd(rs[6:0]);
        foreach (oc[j]) begin
            cmd(oc[j]);
            repeat (3) begin
                @(posedge ref_clk_i);
                host.slow = int'(rs[1:0]);
                host.txq.push_back(rs[7:0]);
                oq.push_back(rs[7:0]);
            end
            @(negedge ref_clk_i iff (oq.size() == 0 && out_req_o === 1'b1));
            rd(12'h008, 32'h00000000, 1'b0);
        end
        cmd(7'h18);
        load(1'b1);
        load(1'b1);
        cmd(7'h68);
        load(1'b0);
        rd(12'h00c, 32'h00000000, 1'b0);
        apb(1'b1, 12'h004, 32'h00000001, r, e);
        st[0] = 1'b1;
        rd(12'h000, st, 1'b0);
        cmd(7'h00);
        conclude();
    end
endmodule // cfh_port_tb
